// [hdl/aog_address_operand_generator.sv]
// aog_address_operand_generator: shifter operand and transfer
// address generation, one registered result per request.
// assumes: decoder supplies split fields, register file supplies
// base, index and shift register values in the request cycle.
`timescale 1ns/10ps

module aog_address_operand_generator
	import aog_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// request and register values
	input  wire aog_req_type  req_i,
	input  wire aog_regs_type regs_i,
	// registered result
	output aog_res_type       res_o
);

	// ==========================================================
	// shifter
	// result is {carry, value}; amount is a full byte so that
	// register-specified shifts of 32 and above resolve here
	function automatic logic [32:0] shift_op(
		input aog_shift_type kind,
		input logic [31:0]   val,
		input logic [7:0]    amt,
		input logic          cin
	);
		logic [63:0] wide;
		logic [4:0]  rot;
		logic [32:0] res;
		wide = 64'h0000_0000_0000_0000;
		rot  = amt[4:0];
		res  = {cin, val};
		case (kind)
			AOG_LOGICAL_LEFT_SHIFT: begin
				if (amt == 8'h00) begin
					res = {cin, val};
				end else if (amt < 8'h20) begin
					wide = {32'h0000_0000, val} << amt;
					res  = {wide[32], wide[31:0]};
				end else if (amt == 8'h20) begin
					res = {val[0], AOG_ZERO_WORD};
				end else begin
					res = {1'b0, AOG_ZERO_WORD};
				end
			end
			AOG_LOGICAL_RIGHT_SHIFT: begin
				if (amt == 8'h00) begin
					res = {cin, val};
				end else if (amt < 8'h20) begin
					wide = {val, 32'h0000_0000} >> amt;
					res  = {wide[31], wide[63:32]};
				end else if (amt == 8'h20) begin
					res = {val[31], AOG_ZERO_WORD};
				end else begin
					res = {1'b0, AOG_ZERO_WORD};
				end
			end
			AOG_ARITHMETIC_RIGHT_SHIFT: begin
				if (amt == 8'h00) begin
					res = {cin, val};
				end else if (amt < 8'h20) begin
					wide = {{32{val[31]}}, val} >> amt;
					res  = {val[amt[4:0] - 5'h01], wide[31:0]};
				end else begin
					// saturates to the sign for 32 and beyond
					res = {val[31], {32{val[31]}}};
				end
			end
			AOG_ROTATE_RIGHT: begin
				if (amt == 8'h00) begin
					res = {cin, val};
				end else if (rot == 5'h00) begin
					res = {val[31], val};
				end else begin
					wide = {val, val} >> rot;
					res  = {wide[31], wide[31:0]};
				end
			end
			AOG_ROTATE_RIGHT_THROUGH_CARRY: begin
				res = {val[0], cin, val[31:1]};
			end
			default: begin
				res = {cin, val};
			end
		endcase
		return res;
	endfunction

	// ==========================================================
	// immediate shift amount: a field of zero with a right shift
	// means a full 32-bit shift, which the byte amount expresses
	function automatic logic [7:0] imm_amount(
		input aog_shift_type kind,
		input logic [4:0]    imm
	);
		logic [7:0] amt;
		amt = {3'h0, imm};
		if (imm == 5'h00 &&
		    (kind == AOG_LOGICAL_RIGHT_SHIFT ||
		     kind == AOG_ARITHMETIC_RIGHT_SHIFT)) begin
			amt = {2'h0, AOG_FULL_SHIFT};
		end
		return amt;
	endfunction

	// ==========================================================
	// stack alias to sequence; loads and stores share one table
	function automatic aog_seq_type stack_seq(
		input aog_stack_type st
	);
		aog_seq_type s;
		s = AOG_INCREMENT_AFTER;
		case (st)
			AOG_FULL_DESCENDING_STACK:  s = AOG_INCREMENT_AFTER;
			AOG_EMPTY_DESCENDING_STACK: s = AOG_INCREMENT_BEFORE;
			AOG_FULL_ASCENDING_STACK:   s = AOG_DECREMENT_AFTER;
			AOG_EMPTY_ASCENDING_STACK:  s = AOG_DECREMENT_BEFORE;
			default:                    s = AOG_INCREMENT_AFTER;
		endcase
		return s;
	endfunction

	// ==========================================================
	// next-value logic
	aog_res_type res_reg;
	aog_res_type res_next;

	logic [32:0] sh_res;
	logic [7:0]  sh_amt;
	logic [31:0] offset;
	logic [31:0] offset_addr;
	logic [31:0] span;
	logic [31:0] span_minus;
	aog_seq_type seq;

	// shifter input: register byte or immediate amount
	always_comb begin
		if (req_i.shift_by_reg) begin
			sh_amt = regs_i.shift_reg[7:0];
		end else begin
			sh_amt = imm_amount(req_i.shift_kind, req_i.shift_imm);
		end
		sh_res = shift_op(req_i.shift_kind, regs_i.index, sh_amt,
		                  regs_i.carry);
	end

	// offset magnitude per procedure, before the sign
	always_comb begin
		offset = AOG_ZERO_WORD;
		case (req_i.proc)
			AOG_WORD_BYTE: begin
				if (req_i.use_reg) begin
					offset = sh_res[31:0];
				end else begin
					offset = {20'h0_0000, req_i.imm12};
				end
			end
			AOG_HALFWORD: begin
				if (req_i.use_reg) begin
					offset = regs_i.index;
				end else begin
					offset = {24'h00_0000, req_i.imm8};
				end
			end
			AOG_COPROCESSOR: begin
				offset = {22'h00_0000, req_i.imm8, 2'h0};
			end
			default: begin
				offset = AOG_ZERO_WORD;
			end
		endcase
		// sign on the final offset; sums wrap at 32 bits
		if (req_i.add) begin
			offset_addr = regs_i.base + offset;
		end else begin
			offset_addr = regs_i.base - offset;
		end
	end

	// multiple transfer span: four bytes per listed register
	always_comb begin
		span       = {25'h000_0000, req_i.reg_count, 2'h0};
		span_minus = span - AOG_WORD_BYTES;
		if (req_i.use_stack) begin
			seq = stack_seq(req_i.stack);
		end else begin
			seq = req_i.seq;
		end
	end

	// result assembly, one per procedure
	always_comb begin
		res_next             = res_reg;
		res_next.valid       = req_i.valid;
		res_next.wb_en       = 1'b0;
		res_next.form_error  = 1'b0;
		res_next.user_access = 1'b0;
		if (req_i.valid) begin
			res_next.operand     = AOG_ZERO_WORD;
			res_next.shift_carry = regs_i.carry;
			res_next.address     = regs_i.base;
			res_next.wb_data     = regs_i.base;
			case (req_i.proc)
				AOG_SECOND_OPERAND: begin
					if (req_i.use_reg) begin
						res_next.operand     = sh_res[31:0];
						res_next.shift_carry = sh_res[32];
					end else begin
						res_next.operand = req_i.imm32;
					end
				end
				AOG_WORD_BYTE,
				AOG_HALFWORD,
				AOG_COPROCESSOR: begin
					// user variant only on word/byte transfers
					if (req_i.user &&
					    req_i.proc == AOG_WORD_BYTE) begin
						res_next.user_access = 1'b1;
					end
					if (req_i.proc == AOG_WORD_BYTE &&
					    req_i.use_reg) begin
						res_next.shift_carry = sh_res[32];
					end
					case (req_i.form)
						AOG_FORM_PRE: begin
							res_next.address = offset_addr;
							if (req_i.user &&
							    req_i.proc == AOG_WORD_BYTE) begin
								// no pre-indexed user form: flag, no update
								res_next.form_error = 1'b1;
							end else begin
								res_next.wb_data = offset_addr;
								res_next.wb_en   = 1'b1;
							end
						end
						AOG_FORM_POST: begin
							res_next.address = regs_i.base;
							res_next.wb_data = offset_addr;
							res_next.wb_en   = 1'b1;
						end
						AOG_FORM_OFFSET: begin
							res_next.address = offset_addr;
						end
						default: begin
							res_next.form_error = 1'b1;
						end
					endcase
				end
				AOG_MULTIPLE: begin
					// start address is the lowest word transferred
					case (seq)
						AOG_INCREMENT_AFTER: begin
							res_next.address = regs_i.base;
							res_next.wb_data = regs_i.base + span;
						end
						AOG_INCREMENT_BEFORE: begin
							res_next.address = regs_i.base +
							                   AOG_WORD_BYTES;
							res_next.wb_data = regs_i.base + span;
						end
						AOG_DECREMENT_AFTER: begin
							res_next.address = regs_i.base - span_minus;
							res_next.wb_data = regs_i.base - span;
						end
						default: begin
							res_next.address = regs_i.base - span;
							res_next.wb_data = regs_i.base - span;
						end
					endcase
					// decoder gates writeback with its own ! bit
					res_next.wb_en = 1'b1;
				end
				default: begin
					res_next.form_error = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// result register; holds operand, carry, address and wb_data while no request; valid and flags clear
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			res_reg <= '0;
		end else begin
			res_reg <= res_next;
		end
	end

	assign res_o = res_reg;

endmodule

// [hdl/aog_pkg.sv]
// aog_pkg: types and constants of the address and operand generator.
// assumes: one core clock; decoder fields arrive already split out.
package aog_pkg;

	// ==========================================================
	// widths and fixed figures
	localparam int unsigned    AOG_WORD_W     = 32;
	localparam logic [5:0]     AOG_FULL_SHIFT = 6'h20;
	localparam logic [31:0]    AOG_WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0]    AOG_ZERO_WORD  = 32'h0000_0000;

	// ==========================================================
	// procedure selection, one per instruction class
	typedef enum logic [2:0] {
		AOG_SECOND_OPERAND = 3'h0,
		AOG_WORD_BYTE      = 3'h1,
		AOG_HALFWORD       = 3'h2,
		AOG_MULTIPLE       = 3'h3,
		AOG_COPROCESSOR    = 3'h4
	} aog_proc_type;

	// indexing form of single transfers
	typedef enum logic [1:0] {
		AOG_FORM_OFFSET = 2'h0,
		AOG_FORM_PRE    = 2'h1,
		AOG_FORM_POST   = 2'h2
	} aog_form_type;

	// shift kinds of the shifter
	typedef enum logic [2:0] {
		AOG_NO_SHIFT                   = 3'h0,
		AOG_LOGICAL_LEFT_SHIFT         = 3'h1,
		AOG_LOGICAL_RIGHT_SHIFT        = 3'h2,
		AOG_ARITHMETIC_RIGHT_SHIFT     = 3'h3,
		AOG_ROTATE_RIGHT               = 3'h4,
		AOG_ROTATE_RIGHT_THROUGH_CARRY = 3'h5
	} aog_shift_type;

	// multiple transfer sequencing
	typedef enum logic [1:0] {
		AOG_INCREMENT_AFTER  = 2'h0,
		AOG_INCREMENT_BEFORE = 2'h1,
		AOG_DECREMENT_AFTER  = 2'h2,
		AOG_DECREMENT_BEFORE = 2'h3
	} aog_seq_type;

	// stack-type aliases
	typedef enum logic [1:0] {
		AOG_FULL_DESCENDING_STACK  = 2'h0,
		AOG_EMPTY_DESCENDING_STACK = 2'h1,
		AOG_FULL_ASCENDING_STACK   = 2'h2,
		AOG_EMPTY_ASCENDING_STACK  = 2'h3
	} aog_stack_type;

	// ==========================================================
	// request from the decoder
	typedef struct packed {
		logic          valid;
		aog_proc_type  proc;
		aog_form_type  form;
		logic          user;
		logic          add;
		logic          use_reg;
		aog_shift_type shift_kind;
		logic          shift_by_reg;
		logic [4:0]    shift_imm;
		logic [31:0]   imm32;
		logic [11:0]   imm12;
		logic [7:0]    imm8;
		aog_seq_type   seq;
		logic          use_stack;
		aog_stack_type stack;
		logic [4:0]    reg_count;
	} aog_req_type;

	// values from the register file
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] index;
		logic [31:0] shift_reg;
		logic        carry;
	} aog_regs_type;

	// result towards ALU and memory interface
	typedef struct packed {
		logic        valid;
		logic [31:0] operand;
		logic        shift_carry;
		logic [31:0] address;
		logic [31:0] wb_data;
		logic        wb_en;
		logic        user_access;
		logic        form_error;
	} aog_res_type;

endpackage

// [verif/aog_monitor.sv]
// aog_monitor: port checks on the operand and address generator.
// assumes: bound to the generator, one clock, async low reset.
`timescale 1ns/10ps
module aog_monitor
	import aog_pkg::*;
(
	// watched ports
	input wire logic         clk_i,
	input wire logic         resetn_i,
	input wire aog_req_type  req_i,
	input wire aog_regs_type regs_i,
	input wire aog_res_type  res_o
);
	// ==========================================================
	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// request kinds
	wire logic op_q = req_i.valid && req_i.proc == AOG_SECOND_OPERAND;
	wire logic wb_q = req_i.valid && req_i.proc == AOG_WORD_BYTE;
	AST_ONE_CYCLE: assert property ($past(resetn_i) |->
		res_o.valid == $past(req_i.valid))
		else $error("result valid not one cycle after request");
	AST_IMM_OPERAND: assert property (op_q && !req_i.use_reg |=>
		res_o.operand == $past(req_i.imm32)
		&& res_o.shift_carry == $past(regs_i.carry))
		else $error("immediate operand wrong");
	AST_PLAIN_REG: assert property (op_q && req_i.use_reg
		&& req_i.shift_kind == AOG_NO_SHIFT
		|=> res_o.operand == $past(regs_i.index))
		else $error("unshifted register operand wrong");
	AST_THROUGH_CARRY: assert property (op_q && req_i.use_reg
		&& req_i.shift_kind == AOG_ROTATE_RIGHT_THROUGH_CARRY |=>
		res_o.operand == {$past(regs_i.carry), $past(regs_i.index[31:1])}
		&& res_o.shift_carry == $past(regs_i.index[0]))
		else $error("rotate through carry wrong");
	AST_POST_ADDR: assert property (wb_q
		&& req_i.form == AOG_FORM_POST
		|=> res_o.address == $past(regs_i.base) && res_o.wb_en)
		else $error("post-indexed address not base");
	AST_PRE_WB: assert property (wb_q && !req_i.user
		&& req_i.form == AOG_FORM_PRE
		|=> res_o.wb_en && res_o.wb_data == res_o.address)
		else $error("pre-indexed writeback wrong");
	AST_USER_PRE: assert property (wb_q && req_i.user
		&& req_i.form == AOG_FORM_PRE
		|=> !res_o.wb_en && res_o.form_error && res_o.user_access)
		else $error("user pre-indexed not refused");
	// both signs: the stimulus reaches pre-indexed only subtracting
	AST_COPRO: assert property (req_i.valid
		&& req_i.proc == AOG_COPROCESSOR && req_i.form == AOG_FORM_PRE
		|=> res_o.address == ($past(req_i.add)
		? $past(regs_i.base) + {$past(req_i.imm8), 2'h0}
		: $past(regs_i.base) - {$past(req_i.imm8), 2'h0}))
		else $error("coprocessor address wrong");
	AST_MULT_DB: assert property (req_i.valid
		&& req_i.proc == AOG_MULTIPLE && !req_i.use_stack
		&& req_i.seq == AOG_DECREMENT_BEFORE
		|=> res_o.address == $past(regs_i.base)
		- {$past(req_i.reg_count), 2'h0}
		&& res_o.wb_data == res_o.address)
		else $error("decrement before address wrong");
endmodule

bind aog_address_operand_generator aog_monitor i_aog_monitor (
	.clk_i   (clk_i),
	.resetn_i(resetn_i),
	.req_i   (req_i),
	.regs_i  (regs_i),
	.res_o   (res_o)
);

// [verif/aog_regfile_model.sv]
// aog_regfile_model: register file in front of the generator.
// assumes: bench loads values; writeback retargets the base.
`timescale 1ns/10ps
module aog_regfile_model
	import aog_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// bench load and generator result
	input  wire logic         load_i,
	input  wire aog_regs_type load_val_i,
	input  wire aog_res_type  res_i,
	// values to the generator
	output aog_regs_type      regs_o
);
	// load wins; a writeback lands one cycle after the result,
	// so dependent requests must be spaced to see it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			regs_o <= '0;
		end else if (load_i) begin
			regs_o <= load_val_i;
		end else if (res_i.valid && res_i.wb_en) begin
			regs_o.base <= res_i.wb_data;
		end
	end
endmodule

// [verif/testbench.sv]
// testbench: drives requests, queues expectations, checks results.
// assumes: one result per request, one cycle later.
`timescale 1ns/10ps
module testbench
	import aog_pkg::*;
();
	// expectation note
	typedef struct packed {
		logic        addr;
		logic [31:0] a;
		logic [31:0] b;
		logic        c;
		logic        wb;
		logic        ua;
		logic        fe;
	} aog_tb_exp_type;
	logic           clk_i    = 1'b0;
	logic           resetn_i = 1'b0;
	logic           ld       = 1'b0;
	aog_regs_type   ld_val   = '0;
	aog_req_type    req_i    = '0;
	aog_regs_type   regs_i;
	aog_res_type    res_o;
	aog_tb_exp_type exp_q[$];
	aog_tb_exp_type e;
	int             fail_count = 0;
	int             checked    = 0;
	int             cyc        = 0;

	// ==========================================================
	// design and partner
	aog_address_operand_generator i_aog_address_operand_generator (
		.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
		.regs_i(regs_i), .res_o(res_o));
	aog_regfile_model i_aog_regfile_model (
		.clk_i(clk_i), .resetn_i(resetn_i), .load_i(ld),
		.load_val_i(ld_val), .res_i(res_o), .regs_o(regs_i));
	always #50 clk_i = ~clk_i;

	// ==========================================================
	// helpers
	task automatic check(string n, logic [31:0] s, logic [31:0] x);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// {carry, value}; amounts 1..31 only
	function automatic logic [32:0] shf(aog_shift_type k,
		logic [31:0] v, logic [4:0] a, logic ci);
		case (k)
		AOG_LOGICAL_LEFT_SHIFT: return {v[32-a], v << a};
		AOG_LOGICAL_RIGHT_SHIFT: return {v[a-1], v >> a};
		AOG_ARITHMETIC_RIGHT_SHIFT: return {v[a-1], $signed(v) >>> a};
		AOG_ROTATE_RIGHT: return {v[a-1], (v >> a) | (v << (32-a))};
		AOG_ROTATE_RIGHT_THROUGH_CARRY: return {v[0], ci, v[31:1]};
		default: return {ci, v};
		endcase
	endfunction
	function automatic aog_tb_exp_type ax(aog_req_type r,
		logic [31:0] b, logic [31:0] o);
		aog_tb_exp_type x;
		x = '0;
		x.addr = 1'b1;
		x.b = r.add ? b + o : b - o;
		x.a = (r.form == AOG_FORM_POST) ? b : x.b;
		x.fe = r.user && r.form == AOG_FORM_PRE;
		x.wb = r.form != AOG_FORM_OFFSET && !x.fe;
		x.ua = r.user && r.proc == AOG_WORD_BYTE;
		return x;
	endfunction
	// load registers, then one request, spaced for writeback
	task automatic send(aog_req_type r, logic l, aog_regs_type v,
		aog_tb_exp_type x);
		@(posedge clk_i);
		ld <= l;
		ld_val <= v;
		@(posedge clk_i);
		ld <= 1'b0;
		r.valid = 1'b1;
		req_i <= r;
		exp_q.push_back(x);
		@(posedge clk_i);
		req_i.valid <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// ==========================================================
	// result watcher and hang limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end else if (resetn_i === 1'b1 && res_o.valid === 1'b1) begin
			e = exp_q.pop_front();
			if (e.addr) begin
				check("address", res_o.address, e.a);
				check("wb_en", 32'(res_o.wb_en), 32'(e.wb));
				if (e.wb) check("wb_data", res_o.wb_data, e.b);
				check("user", 32'(res_o.user_access), 32'(e.ua));
				check("ferr", 32'(res_o.form_error), 32'(e.fe));
			end else begin
				check("operand", res_o.operand, e.a);
				check("carry", 32'(res_o.shift_carry), 32'(e.c));
			end
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		aog_req_type    r;
		aog_regs_type   v;
		aog_tb_exp_type x;
		logic [32:0]    s;
		logic [31:0]    o;
		void'($urandom(32'h77eb_eaeb));
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		// operand: every shift kind, imm or reg amount, immediate
		for (int k = 0; k < 7; k++) begin
			r = '0;
			v = '0;
			v.index = $urandom();
			v.shift_reg = $urandom_range(31, 1);
			v.carry = k[0];
			r.proc = AOG_SECOND_OPERAND;
			r.imm32 = $urandom();
			r.use_reg = k != 6;
			r.shift_kind = aog_shift_type'(k % 6);
			r.shift_by_reg = k == 1 || k == 3;
			r.shift_imm = v.shift_reg[4:0];
			s = shf(r.shift_kind, v.index, r.shift_imm, v.carry);
			x = '0;
			x.a = r.use_reg ? s[31:0] : r.imm32;
			x.c = r.use_reg ? s[32] : v.carry;
			send(r, 1'b1, v, x);
		end
		// edge amounts: imm 0 on a right shift is 32, reg byte 32
		r = '0;
		v = '0;
		v.index = $urandom();
		v.shift_reg = 32'h0000_0020;
		r.proc = AOG_SECOND_OPERAND;
		r.use_reg = 1'b1;
		r.shift_kind = AOG_LOGICAL_RIGHT_SHIFT;
		x = '0;
		x.c = v.index[31];
		send(r, 1'b1, v, x);
		r.shift_kind = AOG_LOGICAL_LEFT_SHIFT;
		r.shift_by_reg = 1'b1;
		x.c = v.index[0];
		send(r, 1'b1, v, x);
		// undefined procedure: flagged, base passed, no writeback
		r = '0;
		r.proc = aog_proc_type'(3'h5);
		v.base = $urandom();
		x = '0;
		x.addr = 1'b1;
		x.a = v.base;
		x.fe = 1'b1;
		send(r, 1'b1, v, x);
		// single transfers: word, user word, halfword, coprocessor
		for (int k = 0; k < 21; k++) begin
			r = '0;
			v = '0;
			v.base = $urandom();
			v.index = $urandom();
			v.carry = 1'b1;
			r.proc = k < 12 ? AOG_WORD_BYTE
				: (k < 18 ? AOG_HALFWORD : AOG_COPROCESSOR);
			r.form = aog_form_type'(k % 3);
			r.add = k[2];
			r.use_reg = k[3] || k == 15;
			r.user = k > 8 && k < 12;
			r.shift_kind = aog_shift_type'(k % 6);
			r.shift_imm = 5'($urandom_range(31, 1));
			r.imm12 = 12'($urandom());
			r.imm8 = 8'($urandom());
			s = shf(r.shift_kind, v.index, r.shift_imm, v.carry);
			o = r.use_reg ? s[31:0] : 32'(r.imm12);
			if (r.proc == AOG_HALFWORD) o = r.use_reg ? v.index : 32'(r.imm8);
			if (r.proc == AOG_COPROCESSOR) o = 32'({r.imm8, 2'h0});
			send(r, 1'b1, v, ax(r, v.base, o));
		end
		// base written back wraps and feeds the next request
		r = '0;
		r.proc = AOG_WORD_BYTE;
		r.form = AOG_FORM_PRE;
		r.add = 1'b1;
		r.imm12 = 12'hffc;
		v = '0;
		v.base = 32'hffff_fff0;
		x = ax(r, v.base, 32'h0000_0ffc);
		send(r, 1'b1, v, x);
		r.form = AOG_FORM_POST;
		r.add = 1'b0;
		send(r, 1'b0, v, ax(r, x.b, 32'h0000_0ffc));
		// multiple: four sequences, then four stack aliases
		for (int k = 0; k < 8; k++) begin
			r = '0;
			v = '0;
			v.base = $urandom();
			r.proc = AOG_MULTIPLE;
			r.use_stack = k[2];
			r.stack = aog_stack_type'(k % 4);
			r.seq = aog_seq_type'((k + k / 4) % 4);
			r.reg_count = 5'($urandom_range(16, 1));
			o = 32'({r.reg_count, 2'h0});
			x = '0;
			x.addr = 1'b1;
			x.wb = 1'b1;
			x.b = k[1] ? v.base - o : v.base + o;
			x.a = k[1] ? x.b : v.base;
			if (k % 4 == 1 || k % 4 == 2) x.a = x.a + 32'h0000_0004;
			send(r, 1'b1, v, x);
		end
		check("pending", 32'(exp_q.size()), 32'h0000_0000);
		final_report();
	end
endmodule
